// ---- aie_core.sv ----
// four-phase execute unit for the literal-add and register-add instructions
//
// Overview of operation
// - literal add sums literal into working register
// - register add sums working and file register
// - destination 0 writes working register only
// - destination 1 writes back file register
// - bank bit 0 uses fixed access bank
// - bank bit 1 uses bank select register
// - extended set, bank 0, low address: indexed
// - register add takes one four-phase cycle
`timescale 1ns/1ps
module aie_core (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // instruction
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [3:0] bank_select_register,
  input wire logic extended_set,
  input wire logic [11:0] index_base,
  // data memory
  input wire logic [7:0] mem_rdata,
  output logic [11:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  // state
  output logic [7:0] wreg,
  output logic [4:0] status_flags,
  output logic busy,
  output logic done,
  output logic [3:0] phase
);
  import aie_pkg::*;

  function automatic logic [11:0] resolve_addr(input logic bank, input logic ext, input logic [7:0] f,
                                               input logic [3:0] bsel, input logic [11:0] base);
    if (bank) begin
      resolve_addr = {bsel, f};
    end else if (ext && f <= INDEXED_LIMIT) begin
      resolve_addr = base + {4'h0, f};
    end else if (f < ACCESS_SPLIT) begin
      resolve_addr = {4'h0, f};
    end else begin
      resolve_addr = {ACCESS_HIGH_BANK, f};
    end
  endfunction

  aie_phase_e state, next_state;
  logic is_lit, next_is_lit;
  logic dest_file, next_dest_file;
  logic [7:0] operand, next_operand;
  logic [7:0] result, next_result;
  logic [4:0] res_flags, next_res_flags;
  logic [7:0] next_wreg;
  logic [4:0] next_status_flags;
  logic [11:0] next_mem_addr;
  logic next_mem_rd, next_mem_wr, next_busy, next_done;
  logic [7:0] next_mem_wdata;
  logic [7:0] add_sum;
  logic [4:0] add_flags;
  logic dec_lit, dec_reg;

  aie_adder u_add (
    .a(wreg),
    .b(operand),
    .sum(add_sum),
    .flags(add_flags)
  );

  always_comb begin
    dec_lit = (instr_word[15:8] == OP_LITERAL_ADD);
    dec_reg = (instr_word[15:10] == OP_REGISTER_ADD);
    next_state = state;
    next_is_lit = is_lit;
    next_dest_file = dest_file;
    next_operand = operand;
    next_result = result;
    next_res_flags = res_flags;
    next_wreg = wreg;
    next_status_flags = status_flags;
    next_mem_addr = mem_addr;
    next_mem_rd = 1'b0;
    next_mem_wr = 1'b0;
    next_mem_wdata = mem_wdata;
    next_busy = busy;
    next_done = 1'b0;
    unique case (state)
      AIE_Q1: begin
        if (instr_valid && (dec_lit || dec_reg)) begin
          next_state = AIE_Q2;
          next_busy = 1'b1;
          next_is_lit = dec_lit;
          next_dest_file = dec_reg && instr_word[DEST_BIT];
          next_operand = instr_word[7:0];
          if (dec_reg) begin
            next_mem_addr = resolve_addr(instr_word[BANK_BIT], extended_set, instr_word[7:0],
                                         bank_select_register, index_base);
            next_mem_rd = 1'b1;
          end
        end
      end
      AIE_Q2: begin
        next_state = AIE_Q3;
        if (!is_lit) begin
          next_operand = mem_rdata;
        end
      end
      AIE_Q3: begin
        next_state = AIE_Q4;
        next_result = add_sum;
        next_res_flags = add_flags;
      end
      AIE_Q4: begin
        next_state = AIE_Q1;
        next_busy = 1'b0;
        next_done = 1'b1;
        next_status_flags = res_flags;
        if (dest_file) begin
          next_mem_wr = 1'b1;
          next_mem_wdata = result;
        end else begin
          next_wreg = result;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= AIE_Q1;
      is_lit <= 1'b0;
      dest_file <= 1'b0;
      operand <= WREG_RESET;
      result <= WREG_RESET;
      res_flags <= FLAGS_RESET;
      wreg <= WREG_RESET;
      status_flags <= FLAGS_RESET;
      mem_addr <= ADDR_RESET;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_wdata <= WDATA_RESET;
      busy <= 1'b0;
      done <= 1'b0;
      phase <= AIE_Q1;
    end else begin
      state <= next_state;
      is_lit <= next_is_lit;
      dest_file <= next_dest_file;
      operand <= next_operand;
      result <= next_result;
      res_flags <= next_res_flags;
      wreg <= next_wreg;
      status_flags <= next_status_flags;
      mem_addr <= next_mem_addr;
      mem_rd <= next_mem_rd;
      mem_wr <= next_mem_wr;
      mem_wdata <= next_mem_wdata;
      busy <= next_busy;
      done <= next_done;
      phase <= next_state;
    end
  end

  // assertions
  property p_four_phase;
    @(posedge clock) disable iff (!rst_n) $rose(busy) |-> busy[*3] ##1 (done && !busy);
  endproperty
  a_four_phase: assert property (p_four_phase) else $error("instruction not four phases");

  property p_lit_wreg;
    @(posedge clock) disable iff (!rst_n)
      (state == AIE_Q1 && instr_valid && instr_word[15:8] == OP_LITERAL_ADD)
      |=> ##3 (wreg == $past(wreg, 4) + $past(instr_word[7:0], 4));
  endproperty
  a_lit_wreg: assert property (p_lit_wreg) else $error("literal sum wrong");

  property p_lit_no_wr;
    @(posedge clock) disable iff (!rst_n)
      (state == AIE_Q1 && instr_valid && instr_word[15:8] == OP_LITERAL_ADD) |=> !mem_wr[*4];
  endproperty
  a_lit_no_wr: assert property (p_lit_no_wr) else $error("literal add wrote memory");

  property p_reg_read;
    @(posedge clock) disable iff (!rst_n)
      (state == AIE_Q1 && instr_valid && instr_word[15:10] == OP_REGISTER_ADD) |=> mem_rd;
  endproperty
  a_reg_read: assert property (p_reg_read) else $error("file register not read");

  property p_dest_w;
    @(posedge clock) disable iff (!rst_n)
      (state == AIE_Q1 && instr_valid && instr_word[15:10] == OP_REGISTER_ADD && !instr_word[DEST_BIT])
      |=> !mem_wr[*4];
  endproperty
  a_dest_w: assert property (p_dest_w) else $error("destination w wrote memory");

  property p_dest_f;
    @(posedge clock) disable iff (!rst_n)
      (state == AIE_Q1 && instr_valid && instr_word[15:10] == OP_REGISTER_ADD && instr_word[DEST_BIT])
      |=> ##3 (mem_wr && $stable(wreg));
  endproperty
  a_dest_f: assert property (p_dest_f) else $error("destination file not written");

  property p_bank_sel;
    @(posedge clock) disable iff (!rst_n)
      (state == AIE_Q1 && instr_valid && instr_word[15:10] == OP_REGISTER_ADD && instr_word[BANK_BIT])
      |=> (mem_addr == {$past(bank_select_register), $past(instr_word[7:0])});
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("bank select address wrong");

  property p_access;
    @(posedge clock) disable iff (!rst_n)
      (state == AIE_Q1 && instr_valid && instr_word[15:10] == OP_REGISTER_ADD && !instr_word[BANK_BIT]
       && !extended_set && instr_word[7:0] < ACCESS_SPLIT)
      |=> (mem_addr == {4'h0, $past(instr_word[7:0])});
  endproperty
  a_access: assert property (p_access) else $error("access bank address wrong");

  property p_indexed;
    @(posedge clock) disable iff (!rst_n)
      (state == AIE_Q1 && instr_valid && instr_word[15:10] == OP_REGISTER_ADD && !instr_word[BANK_BIT]
       && extended_set && instr_word[7:0] <= INDEXED_LIMIT)
      |=> (mem_addr == $past(index_base) + {4'h0, $past(instr_word[7:0])});
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");

  c_lit: cover property (@(posedge clock) disable iff (!rst_n) done && !mem_wr && is_lit);
  c_reg_f: cover property (@(posedge clock) disable iff (!rst_n) mem_wr);
  c_carry: cover property (@(posedge clock) disable iff (!rst_n) done ##0 status_flags[FLAG_C]);
  c_signed_range: cover property (@(posedge clock) disable iff (!rst_n) done ##0 status_flags[FLAG_SIGNED_RANGE]);
endmodule

// ---- aie_pkg.sv ----
// package for the add instruction execute block
package aie_pkg;
  localparam logic [7:0] OP_LITERAL_ADD = 8'h0F;
  localparam logic [5:0] OP_REGISTER_ADD = 6'h09;
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [7:0] WREG_RESET = 8'h00;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [11:0] ADDR_RESET = 12'h000;
  localparam logic [7:0] WDATA_RESET = 8'h00;
  localparam int FLAG_C = 0;
  localparam int FLAG_NIBBLE_CARRY = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_SIGNED_RANGE = 3;
  localparam int FLAG_N = 4;
  typedef enum logic [3:0] {
    AIE_Q1 = 4'b0001,
    AIE_Q2 = 4'b0010,
    AIE_Q3 = 4'b0100,
    AIE_Q4 = 4'b1000
  } aie_phase_e;
endpackage

// ---- aie_adder.sv ----
// 8-bit adder producing the five status flags
`timescale 1ns/1ps
module aie_adder (
  // operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  // result
  output logic [7:0] sum,
  output logic [4:0] flags
);
  import aie_pkg::*;
  logic [8:0] full;
  logic [4:0] low;
  always_comb begin
    full = {1'b0, a} + {1'b0, b};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    sum = full[7:0];
    flags = FLAGS_RESET;
    flags[FLAG_C] = full[8];
    flags[FLAG_NIBBLE_CARRY] = low[4];
    flags[FLAG_Z] = (full[7:0] == 8'h00);
    flags[FLAG_SIGNED_RANGE] = (a[7] == b[7]) && (full[7] != a[7]);
    flags[FLAG_N] = full[7];
  end
endmodule

// ---- test_add_instruction_execute.sv ----
// self-checking bench for the add instruction execute core
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module test_add_instruction_execute;
  import aie_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [3:0] bank_select_register = 4'h0;
  logic extended_set = 1'b0;
  logic [11:0] index_base = 12'h200;
  logic [7:0] mem_rdata = 8'h00;
  logic [11:0] mem_addr;
  logic mem_rd;
  logic mem_wr;
  logic [7:0] mem_wdata;
  logic [7:0] wreg;
  logic [4:0] status_flags;
  logic busy;
  logic done;
  logic [3:0] phase;
  logic [7:0] wexp = 8'h00;
  int fails = 0;
  int n_compared = 0;
  always #50 clock = ~clock;
  aie_core dut_u (
    .clock(clock), .rst_n(rst_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .bank_select_register(bank_select_register), .extended_set(extended_set), .index_base(index_base),
    .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .wreg(wreg), .status_flags(status_flags), .busy(busy), .done(done), .phase(phase)
  );
  task automatic summarize;
    if (fails == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one instruction from take edge to done, expectations from the operands
  task automatic exec(input logic [15:0] w, input logic [7:0] rd, input logic [11:0] ea);
    logic reg_op;
    logic [7:0] b;
    logic [8:0] s;
    logic [4:0] lo;
    logic [4:0] ef;
    int n;
    reg_op = (w[15:10] === OP_REGISTER_ADD);
    b = reg_op ? rd : w[7:0];
    s = {1'b0, wexp} + {1'b0, b};
    lo = {1'b0, wexp[3:0]} + {1'b0, b[3:0]};
    ef[FLAG_C] = s[8];
    ef[FLAG_NIBBLE_CARRY] = lo[4];
    ef[FLAG_Z] = (s[7:0] == 8'h00);
    ef[FLAG_SIGNED_RANGE] = (wexp[7] == b[7]) && (s[7] != wexp[7]);
    ef[FLAG_N] = s[7];
    mem_rdata = rd;
    instr_word = w;
    instr_valid = 1'b1;
    @(posedge clock);
    #10 instr_valid = 1'b0;
    `CHK("busy", 1'b1, busy)
    `CHK("phase", AIE_Q2, phase)
    `CHK("mem_rd", reg_op, mem_rd)
    if (reg_op) `CHK("mem_addr", ea, mem_addr)
    n = 1;
    while (done !== 1'b1 && n < 8) begin
      @(posedge clock);
      #10 n++;
    end
    `CHK("cycles", 4, n)
    if (n >= 8) summarize();
    `CHK("end phase", AIE_Q1, phase)
    `CHK("flags", ef, status_flags)
    if (reg_op && w[DEST_BIT]) begin
      `CHK("mem_wr", 1'b1, mem_wr)
      `CHK("mem_wdata", s[7:0], mem_wdata)
      `CHK("wreg kept", wexp, wreg)
    end else begin
      `CHK("no mem_wr", 1'b0, mem_wr)
      `CHK("wreg", s[7:0], wreg)
      wexp = s[7:0];
    end
  endtask
  initial begin
    repeat (20) @(posedge clock);
    #10 rst_n = 1'b1;
    `CHK("reset wreg", WREG_RESET, wreg)
    `CHK("reset flags", FLAGS_RESET, status_flags)
    `CHK("reset busy", 1'b0, busy)
    `CHK("reset phase", AIE_Q1, phase)
    // literal adds: plain, digit carry with overflow, wrap to zero
    exec(16'h0F10, 8'h00, 12'h000);
    exec(16'h0F15, 8'h00, 12'h000);
    exec(16'h0F5B, 8'h00, 12'h000);
    exec(16'h0F80, 8'h00, 12'h000);
    // unmatched opcode is ignored
    instr_word = 16'h0B55;
    instr_valid = 1'b1;
    @(posedge clock);
    #10 instr_valid = 1'b0;
    `CHK("ignored busy", 1'b0, busy)
    `CHK("ignored wreg", wexp, wreg)
    // register adds over banks, access halves and indexed mode
    bank_select_register = 4'h3;
    exec(16'h2742, 8'hC2, 12'h342);
    exec(16'h2542, 8'hC2, 12'h342);
    exec(16'h2680, 8'h17, 12'hF80);
    exec(16'h2410, 8'h01, 12'h010);
    extended_set = 1'b1;
    exec(16'h265F, 8'h33, 12'h25F);
    exec(16'h2460, 8'h44, 12'hF60);
    exec(16'h2700, 8'hFF, 12'h300);
    // request held through busy is taken once only
    instr_word = 16'h0F01;
    instr_valid = 1'b1;
    repeat (4) @(posedge clock);
    #10 instr_valid = 1'b0;
    `CHK("held done", 1'b1, done)
    `CHK("held wreg", 8'h08, wreg)
    @(posedge clock);
    #10 `CHK("held busy", 1'b0, busy)
    `CHK("held wreg kept", 8'h08, wreg)
    summarize();
  end
endmodule
